// ===== async_tx_fifo_status.sv
/*
  Async transmit FIFO status register, normal FIFO storage and memory test port.
  Assumes a host doing one access per cycle, and a link side that pops words.
*/
`timescale 1ns/1ps
`default_nettype none
module async_tx_fifo_status (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        host_cs,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_addr,
  input  wire logic [31:0] host_wdata,
  output logic      [31:0] host_rdata,
  output logic             host_rvalid,
  output logic             host_wready,
  input  wire logic [9:0]  async_tx_fifo_allocation,
  input  wire logic [9:0]  iso_transmit_fifo_allocation,
  input  wire logic        tx_pop,
  output logic             tx_valid,
  output logic      [32:0] tx_data
);
  localparam int SLW = $clog2(atf_pkg::STAGE_DEPTH) + 1;

  // Port decode is shared by the read and write paths.
  function automatic logic is_port(input logic [7:0] a, input logic t);
    return (a == atf_pkg::ADDR_PORT_FIRST) || (!t && a == atf_pkg::ADDR_PORT_NEXT);
  endfunction

  // Circular pointer step inside the allocated share.
  function automatic logic [8:0] bump(input logic [8:0] p, input logic [9:0] sz);
    return ({1'b0, p} + 10'h001 >= sz) ? 9'h000 : p + 9'h001;
  endfunction

  logic [atf_pkg::WORD_W-1:0] mem [atf_pkg::MEM_DEPTH];

  logic        full_r;
  logic        empty_r;
  logic        mism_r;
  logic        clr_r;
  logic        ref_r;
  logic        test_r;
  logic [8:0]  cnt_r;
  logic [8:0]  free_r;
  logic [31:0] host_rdata_r;
  logic        host_rvalid_r;
  logic        host_wready_r;
  logic        tx_valid_r;
  logic [32:0] tx_data_r;
  logic [8:0]  wr_ptr_r;
  logic [8:0]  rd_ptr_r;
  logic [9:0]  ram_used_r;
  logic [9:0]  used_r;

  logic        wr_req;
  logic        rd_req;
  logic        status_wr;
  logic        port_wr;
  logic        port_rd;
  atf_pkg::atf_acc_type acc;
  logic        test_wr;
  logic        test_rd;
  logic        test_acc;
  logic [8:0]  acc_loc;
  logic [32:0] acc_word;
  logic        norm_wr;
  logic        drain;
  logic        load;
  logic        consume;
  logic [9:0]  used_nxt;
  logic [9:0]  eff_size;
  logic [10:0] alloc_sum;
  logic [31:0] status_word;

  logic        stage_in_ready;
  logic        stage_out_valid;
  logic [32:0] stage_out_data;
  logic [SLW-1:0] stage_level;

  assign wr_req    = host_cs & host_wr;
  assign rd_req    = host_cs & host_rd & ~host_wr;
  assign status_wr = wr_req & (host_addr == atf_pkg::ADDR_STATUS);
  assign port_wr   = wr_req & is_port(host_addr, test_r);
  assign port_rd   = rd_req & is_port(host_addr, test_r);

  always_comb begin
    acc = atf_pkg::ATF_ACC_IDLE;
    if ((port_wr || port_rd) && test_r) begin
      acc = atf_pkg::ATF_ACC_TEST;
    end else if (port_wr) begin
      acc = atf_pkg::ATF_ACC_NORM;
    end
  end

  assign test_wr  = (acc == atf_pkg::ATF_ACC_TEST) & wr_req;
  assign test_rd  = (acc == atf_pkg::ATF_ACC_TEST) & rd_req;
  assign test_acc = test_wr | test_rd;
  // A pending clear makes this access use location zero.
  assign acc_loc  = clr_r ? atf_pkg::LOC_ZERO : cnt_r;
  assign acc_word = mem[acc_loc];

  // The share is clamped so both transmit FIFOs fit in common storage.
  always_comb begin
    alloc_sum = {1'b0, async_tx_fifo_allocation} + {1'b0, iso_transmit_fifo_allocation};
    eff_size  = async_tx_fifo_allocation;
    if (async_tx_fifo_allocation > atf_pkg::MEM_SIZE) begin
      eff_size = atf_pkg::MEM_SIZE;
    end
    if (alloc_sum > {1'b0, atf_pkg::MEM_SIZE}) begin
      eff_size = (iso_transmit_fifo_allocation >= atf_pkg::MEM_SIZE) ? 10'h000 :
                 atf_pkg::MEM_SIZE - iso_transmit_fifo_allocation;
    end
  end

  // Writes while full are dropped without any answer to the host.
  assign norm_wr = (acc == atf_pkg::ATF_ACC_NORM) & ~full_r & stage_in_ready;

  // Normal FIFO movement stops entirely in test mode.
  assign drain   = ~test_r & stage_out_valid & (ram_used_r < eff_size);
  assign load    = ~test_r & (ram_used_r != 10'h000) & (~tx_valid_r | tx_pop);
  assign consume = ~test_r & tx_valid_r & tx_pop;

  always_comb begin
    used_nxt = used_r;
    if (norm_wr && !consume) begin
      used_nxt = used_r + 10'h001;
    end else if (consume && !norm_wr) begin
      used_nxt = used_r - 10'h001;
    end
  end

  // The first-quadlet mark rides in the top bit through staging.
  atf_fifo #(
    .WIDTH(atf_pkg::WORD_W),
    .DEPTH(atf_pkg::STAGE_DEPTH)
  ) u_stage (
    .clk      (clk),
    .rst      (rst),
    .in_valid (norm_wr),
    .in_ready (stage_in_ready),
    .in_data  ({host_addr == atf_pkg::ADDR_PORT_FIRST, host_wdata}),
    .out_valid(stage_out_valid),
    .out_ready(drain),
    .out_data (stage_out_data),
    .level    (stage_level)
  );

  // No reset on the storage; test mode exists to check its contents.
  always_ff @(posedge clk) begin
    if (test_wr) begin
      mem[acc_loc] <= {ref_r, host_wdata};
    end else if (drain) begin
      mem[wr_ptr_r] <= stage_out_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= atf_pkg::LOC_ZERO;
    end else if (drain) begin
      wr_ptr_r <= bump(wr_ptr_r, eff_size);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr_r <= atf_pkg::LOC_ZERO;
    end else if (load) begin
      rd_ptr_r <= bump(rd_ptr_r, eff_size);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ram_used_r <= 10'h000;
    end else if (drain && !load) begin
      ram_used_r <= ram_used_r + 10'h001;
    end else if (load && !drain) begin
      ram_used_r <= ram_used_r - 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 33'h0_0000_0000;
    end else if (load) begin
      tx_valid_r <= 1'b1;
      tx_data_r  <= mem[rd_ptr_r];
    end else if (consume) begin
      tx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      used_r <= 10'h000;
    end else begin
      used_r <= used_nxt;
    end
  end

  // Flags come from the next level so a write in the filling cycle is caught.
  always_ff @(posedge clk) begin
    if (rst) begin
      full_r  <= 1'b0;
      empty_r <= 1'b0;
      free_r  <= 9'h000;
    end else begin
      full_r  <= (used_nxt >= eff_size);
      empty_r <= (used_nxt == 10'h000);
      // Nine bits cannot show 512, so an empty full-size share reads 511.
      if (used_nxt >= eff_size) begin
        free_r <= 9'h000;
      end else if (eff_size - used_nxt > {1'b0, atf_pkg::FREE_MAX}) begin
        free_r <= atf_pkg::FREE_MAX;
      end else begin
        free_r <= 9'(eff_size - used_nxt);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      test_r <= 1'b0;
      ref_r  <= 1'b0;
    end else if (status_wr) begin
      test_r <= host_wdata[atf_pkg::BIT_TEST];
      ref_r  <= host_wdata[atf_pkg::BIT_REF];
    end
  end

  // The clear request waits for the next test access, then drops itself.
  always_ff @(posedge clk) begin
    if (rst) begin
      clr_r <= 1'b0;
    end else if (status_wr) begin
      clr_r <= host_wdata[atf_pkg::BIT_CLR] & host_wdata[atf_pkg::BIT_TEST];
    end else if (test_acc) begin
      clr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= atf_pkg::LOC_ZERO;
    end else if (test_acc) begin
      cnt_r <= acc_loc + 9'h001;
    end
  end

  // A mismatch found in the same access that clears wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      mism_r <= 1'b0;
    end else if (test_rd && acc_word[32] != ref_r) begin
      mism_r <= 1'b1;
    end else if (status_wr && (host_wdata[atf_pkg::BIT_CLR] || !host_wdata[atf_pkg::BIT_TEST])) begin
      mism_r <= 1'b0;
    end else if (test_acc && clr_r) begin
      mism_r <= 1'b0;
    end
  end

  always_comb begin
    status_word = atf_pkg::STATUS_RESET;
    status_word[atf_pkg::BIT_FULL]  = full_r;
    status_word[atf_pkg::BIT_EMPTY] = empty_r;
    status_word[atf_pkg::BIT_MISM]  = mism_r;
    status_word[atf_pkg::BIT_CLR]   = clr_r;
    status_word[atf_pkg::BIT_REF]   = ref_r;
    status_word[atf_pkg::BIT_TEST]  = test_r;
    status_word[atf_pkg::CNT_MSB:atf_pkg::CNT_LSB]   = cnt_r;
    status_word[atf_pkg::FREE_MSB:atf_pkg::FREE_LSB] = free_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata_r  <= atf_pkg::STATUS_RESET;
      host_rvalid_r <= 1'b0;
    end else begin
      host_rvalid_r <= rd_req;
      if (rd_req && host_addr == atf_pkg::ADDR_STATUS) begin
        host_rdata_r <= status_word;
      end else if (test_rd) begin
        host_rdata_r <= acc_word[atf_pkg::QUAD_W-1:0];
      end else if (rd_req) begin
        host_rdata_r <= atf_pkg::RDATA_UNMAPPED;
      end
    end
  end

  // Ready is taken one slot early because the flop lags a push by a cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      host_wready_r <= 1'b0;
    end else begin
      host_wready_r <= test_r | (SLW'(stage_level) < SLW'(atf_pkg::STAGE_DEPTH - 1));
    end
  end

  assign host_rdata  = host_rdata_r;
  assign host_rvalid = host_rvalid_r;
  assign host_wready = host_wready_r;
  assign tx_valid    = tx_valid_r;
  assign tx_data     = tx_data_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_FULL_DROP: assert property (
    full_r && acc == atf_pkg::ATF_ACC_NORM && !consume
    |=> used_r == $past(used_r))
    else $error("Write while full changed the level.");

  AST_EMPTY_FLAG: assert property (
    used_r == 10'h000 && !norm_wr |=> empty_r)
    else $error("Empty flag missing with nothing stored.");

  AST_MISMATCH: assert property (
    test_rd && acc_word[32] != ref_r |=> mism_r ##1 (mism_r || $past(status_wr)))
    else $error("Flag mismatch not reported.");

  AST_EXIT_CLEAR: assert property (
    status_wr && !host_wdata[atf_pkg::BIT_TEST] |=> !mism_r && !test_r)
    else $error("Leaving test mode kept the mismatch flag.");

  AST_CLR_ZERO: assert property (
    clr_r && test_acc |=> cnt_r == 9'h001 && !clr_r)
    else $error("Address clear did not restart at location 0.");

  AST_TEST_STORE: assert property (
    test_wr |=> mem[$past(acc_loc)] == {$past(ref_r), $past(host_wdata)})
    else $error("Test write stored the wrong word.");

  AST_TEST_READ: assert property (
    test_rd |=> host_rvalid_r && host_rdata_r == $past(acc_word[31:0]))
    else $error("Test read returned the wrong location.");

  AST_SUSPEND: assert property (
    test_r |=> $stable(rd_ptr_r) && $stable(wr_ptr_r) && $stable(used_r))
    else $error("Normal FIFO moved during test mode.");

  AST_STEP: assert property (
    test_acc && !clr_r |=> cnt_r == $past(cnt_r) + 9'h001)
    else $error("Location counter did not step by one.");

  AST_WRAP: assert property (
    test_acc && !clr_r && cnt_r == 9'h1FF |=> cnt_r == 9'h000)
    else $error("Location counter did not wrap to 0.");

  AST_NORM_HOLD: assert property (
    !test_r && !status_wr |=> $stable(cnt_r) && !clr_r)
    else $error("Counter moved outside test mode.");

  AST_FREE: assert property (
    used_r >= eff_size && $stable(eff_size) |-> free_r == 9'h000 && full_r)
    else $error("Free count not zero when full.");
endmodule
`default_nettype wire

// ===== atf_pkg.sv
/*
  Shared constants for the async transmit FIFO status and memory test block.
  Assumes a 32-bit host data bus with byte addresses on 8 bits.
*/
`default_nettype none
package atf_pkg;
  // Host addresses.
  localparam logic [7:0] ADDR_STATUS     = 8'h30;
  localparam logic [7:0] ADDR_PORT_FIRST = 8'h80;
  localparam logic [7:0] ADDR_PORT_NEXT  = 8'h84;

  // Field positions of the status register.
  localparam int BIT_FULL  = 0;
  localparam int BIT_EMPTY = 1;
  localparam int BIT_MISM  = 2;
  localparam int BIT_CLR   = 3;
  localparam int BIT_REF   = 4;
  localparam int BIT_TEST  = 5;
  localparam int CNT_LSB   = 6;
  localparam int CNT_MSB   = 14;
  localparam int FREE_LSB  = 23;
  localparam int FREE_MSB  = 31;

  // Reset value, and the read data for unmapped addresses.
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  // Storage shape.
  localparam int QUAD_W      = 32;
  localparam int WORD_W      = 33;
  localparam int MEM_AW      = 9;
  localparam int MEM_DEPTH   = 512;
  localparam int STAGE_DEPTH = 8;
  localparam logic [9:0] MEM_SIZE  = 10'h200;
  localparam logic [8:0] FREE_MAX  = 9'h1FF;
  localparam logic [8:0] LOC_ZERO  = 9'h000;

  // Which path a host access takes.
  typedef enum logic [2:0] {
    ATF_ACC_IDLE = 3'b001,
    ATF_ACC_TEST = 3'b010,
    ATF_ACC_NORM = 3'b100
  } atf_acc_type;
endpackage
`default_nettype wire

// ===== atf_fifo.sv
/*
  Small synchronous staging FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module atf_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    head_r;
  logic [AW-1:0]    tail_r;
  logic [AW:0]      level_r;
  logic             push;
  logic             pop;

  assign in_ready  = (level_r != DEPTH[AW:0]);
  assign out_valid = (level_r != '0);
  assign out_data  = store[head_r];
  assign level     = level_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[tail_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tail_r <= '0;
    end else if (push) begin
      tail_r <= (tail_r == AW'(DEPTH - 1)) ? '0 : tail_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_r <= '0;
    end else if (pop) begin
      head_r <= (head_r == AW'(DEPTH - 1)) ? '0 : head_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= '0;
    end else if (push && !pop) begin
      level_r <= level_r + 1'b1;
    end else if (pop && !push) begin
      level_r <= level_r - 1'b1;
    end
  end

  AST_FIFO_NO_OVERRUN: assert property (@(posedge clk) disable iff (rst)
    level_r == DEPTH[AW:0] && !pop |=> level_r == DEPTH[AW:0])
    else $error("Staging FIFO level moved past full.");
endmodule
`default_nettype wire

// ===== atf_link_model.sv
/*
  Link-side partner that takes words from the transmit output.
  Assumes the bench drives stall and slow, and checks what is popped itself.
*/
`timescale 1ns/1ps
`default_nettype none
module atf_link_model #(
  parameter logic [31:0] SEED = 32'h0000_1234
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic slow,
  output var  logic tx_pop
);
  integer s = SEED;
  initial tx_pop = 1'b0;
  // A slow link pops on about half the cycles, so the stream gets bubbles.
  always @(posedge clk) begin
    #1 tx_pop = !rst && !stall && (!slow || ($random(s) % 2 != 0));
  end
endmodule
`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench for the async transmit FIFO status and test port.
  Assumes async_tx_fifo_status, its staging FIFO and the link model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [9:0]  alloc = 10'h200;
  logic [9:0]  iso = 10'h000;
  logic        stall = 1'b1;
  logic        slow = 1'b0;
  logic [31:0] rdata;
  logic        rvalid;
  logic        wready;
  logic        tx_pop;
  logic        tx_valid;
  logic [32:0] tx_data;
  integer      seed = 32'hFF9B2966;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          i;
  int          k;
  int          n;
  logic [32:0] q[$];
  logic [32:0] ex;
  logic [31:0] rv;
  logic [31:0] d0;
  logic [31:0] d[6];
  logic        r[6];
  logic [8:0]  na;

  async_tx_fifo_status uut (.clk(clk), .rst(rst), .host_cs(cs), .host_wr(wr), .host_rd(rd),
    .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid),
    .host_wready(wready), .async_tx_fifo_allocation(alloc),
    .iso_transmit_fifo_allocation(iso), .tx_pop(tx_pop), .tx_valid(tx_valid),
    .tx_data(tx_data));
  atf_link_model #(.SEED(32'h5A5A_0F0F)) link (.clk(clk), .rst(rst), .stall(stall),
    .slow(slow), .tx_pop(tx_pop));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end

  // Every word the link takes must be the next one written, in order.
  always @(posedge clk) begin
    if (!rst && tx_valid === 1'b1 && tx_pop === 1'b1) begin
      ex = (q.size() == 0) ? 33'h0_0000_0000 : q.pop_front();
      `CHK(tx_data, ex)
    end
  end

  function automatic logic [31:0] st(input logic [8:0] fr, input logic [5:0] lo);
    return {fr, 8'h00, 9'h000, lo};
  endfunction

  function automatic logic [31:0] tm(input logic rf, input logic cl);
    return {26'h0, 1'b1, rf, cl, 3'b000};
  endfunction

  // A port write waits for room first only when w is set, so only the full-flag test loses data.
  task automatic wr_t(input logic [7:0] a, input logic [31:0] v, input logic w);
    int j;
    j = 0;
    @(posedge clk);
    #1;
    while (w && wready !== 1'b1 && j < 100) begin
      @(posedge clk);
      #1;
      j++;
    end
    cs = 1'b1;
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk);
    #1 cs = 1'b0;
    wr = 1'b0;
  endtask

  task automatic rd_t(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    #1 cs = 1'b1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 cs = 1'b0;
    rd = 1'b0;
    v = rdata;
    `CHK(rvalid, 1'b1)
  endtask

  task automatic drain_t;
    int j;
    j = 0;
    while ((q.size() != 0 || tx_valid !== 1'b0) && j < 4000) begin
      @(posedge clk);
      j++;
    end
    `CHK(q.size(), 0)
    `CHK(tx_valid, 1'b0)
    repeat (3) @(posedge clk);
  endtask

  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    rd_t(8'h30, rv);
    `CHK(rv, st(9'h1FF, 6'b000010))
    rd_t(8'h44, rv);
    `CHK(rv, 32'h0000_0000)
    wr_t(8'h30, 32'hFFFF_FFDF, 1'b0);
    rd_t(8'h30, rv);
    `CHK(rv, st(9'h1FF, 6'b010010))
    wr_t(8'h30, 32'h0000_0000, 1'b0);
    alloc = 10'h12C;
    iso = 10'h12C;
    repeat (3) @(posedge clk);
    rd_t(8'h30, rv);
    `CHK(rv[31:23], 9'h0D4)
    na = 9'(8 + $unsigned($random(seed)) % 33);
    alloc = {1'b0, na};
    iso = 10'($unsigned($random(seed)) % 64);
    repeat (3) @(posedge clk);
    for (i = 0; i < na; i++) begin
      d0 = $random(seed);
      q.push_back({i == 0, d0});
      wr_t((i == 0) ? 8'h80 : 8'h84, d0, 1'b1);
    end
    repeat (3) @(posedge clk);
    rd_t(8'h30, rv);
    `CHK(rv, st(9'h000, 6'b000001))
    `CHK(tx_valid, 1'b1)
    `CHK(tx_data, q[0])
    wr_t(8'h84, 32'hDEAD_BEEF, 1'b0);
    stall = 1'b0;
    slow = 1'b1;
    drain_t();
    rd_t(8'h30, rv);
    `CHK(rv, st(na, 6'b000010))
    slow = 1'b0;
    stall = 1'b1;
    rd_t(8'h30, rv);
    n = 1 + $unsigned($random(seed)) % rv[31:23];
    for (i = 0; i < n; i++) begin
      d0 = $random(seed);
      q.push_back({i == 0, d0});
      wr_t((i == 0) ? 8'h80 : 8'h84, d0, 1'b1);
    end
    rd_t(8'h30, rv);
    `CHK(rv[31:23], 9'(na - n))
    stall = 1'b0;
    drain_t();
    rd_t(8'h30, rv);
    `CHK(rv, st(na, 6'b000010))
    wr_t(8'h30, tm(1'b0, 1'b1), 1'b0);
    rd_t(8'h30, rv);
    `CHK(rv[14:2], {9'h000, 4'b1010})
    `CHK(wready, 1'b1)
    for (k = 0; k < 6; k++) begin
      d[k] = $random(seed);
      r[k] = 1'($random(seed));
      wr_t(8'h30, tm(r[k], k == 0), 1'b0);
      wr_t(8'h80, d[k], 1'b1);
    end
    rd_t(8'h30, rv);
    `CHK(rv[14:6], 9'h006)
    rd_t(8'h84, rv);
    `CHK(rv, 32'h0000_0000)
    for (k = 0; k < 6; k++) begin
      wr_t(8'h30, tm(r[k] ^ (k == 3), k == 0), 1'b0);
      rd_t(8'h80, rv);
      `CHK(rv, d[k])
      rd_t(8'h30, rv);
      `CHK(rv[2], 1'(k >= 3))
    end
    wr_t(8'h30, tm(1'b0, 1'b1), 1'b0);
    rd_t(8'h30, rv);
    `CHK(rv[3:2], 2'b10)
    for (i = 0; i < 511; i++) begin
      wr_t(8'h80, 32'(i * 3 + 1), 1'b1);
    end
    rd_t(8'h30, rv);
    `CHK(rv[14:6], 9'h1FF)
    wr_t(8'h80, 32'h0000_0600, 1'b1);
    rd_t(8'h30, rv);
    `CHK(rv[14:6], 9'h000)
    rd_t(8'h80, rv);
    `CHK(rv, 32'h0000_0001)
    wr_t(8'h30, tm(1'b1, 1'b0), 1'b0);
    rd_t(8'h80, rv);
    rd_t(8'h30, rv);
    `CHK(rv[2], 1'b1)
    wr_t(8'h30, 32'h0000_0000, 1'b0);
    rd_t(8'h30, rv);
    `CHK(rv[5:0], 6'b000010)
    `CHK(rv[31:23], na)
    test_done();
  end
endmodule
`default_nettype wire
